// >>> inc/otp_prog_pkg.sv
// constants and types for the user nonvolatile programming controller
// Summary of operation
// - array writes touch mirror registers only
// - trigger bit 7 write starts programming
// - region 00 bank zero, 01 bank one
// - region 10 needs both extended bits set
// - bank two burn stores the lowpass filter setting as 1000 Hz
// - finished bank sets its lock flag
// - locked bank two gets change detection while idle, a locked shared bank only while idle and it is the base
// - bank two writable, never reprogrammed once locked
// - write to other bank moves shared base
// - checksum, burn, then lock the bank
// - trigger bit stays set, never self-cleared
// - control register read and write accessible
// - control register inside array checksum
// - init lock blocks all register writes
package otp_prog_pkg;
	localparam logic [7:0] ADDR_CTRL     = 8'h11;
	localparam logic [7:0] ADDR_CTRL_RST = 8'h00;
	localparam int         TRIG_BIT      = 7;
	localparam int         EXA_BIT       = 3;
	localparam int         EXB_BIT       = 2;
	localparam int         REGION_LSB    = 0;
	localparam logic [1:0] REGION_B0     = 2'h0;
	localparam logic [1:0] REGION_B1     = 2'h1;
	localparam logic [1:0] REGION_B2     = 2'h2;
	// shared mirror block windows and bank two window, sixteen and four bytes
	localparam logic [3:0] PAGE_B0       = 4'hA;
	localparam logic [3:0] PAGE_B1       = 4'hB;
	localparam logic [3:0] PAGE_B2       = 4'hC;
	localparam int         SHARED_BYTES  = 16;
	localparam int         B2_BYTES      = 4;
	// checksum and lock registers, one per bank
	localparam logic [7:0] ADDR_SUM_B0   = 8'hE0;
	localparam logic [7:0] ADDR_SUM_B1   = 8'hE1;
	localparam logic [7:0] ADDR_SUM_B2   = 8'hE2;
	localparam int         LOCK_BIT      = 7;
	// lowpass setting: byte 0 bit 0 of bank two, 0 selects 1000 Hz
	localparam int         LPF_BIT       = 0;
	localparam logic       LPF_1000HZ    = 1'b0;
	// per-byte cell program time
	localparam int         CLK_KHZ       = 10000;
	localparam int         BYTE_PROG_US  = 500;
	localparam int         BYTE_PROG_CYC = (BYTE_PROG_US * CLK_KHZ) / 1000;
	typedef enum logic [1:0] {BANK_0, BANK_1, BANK_2, BANK_NONE} bank_t;
	typedef enum {ST_IDLE, ST_SUM, ST_BURN, ST_LOCK} prog_state_t;
endpackage

// >>> rtl/otp_prog_ctrl.sv
// user nonvolatile programming controller behind the internal register port
`timescale 1ns/100ps
module otp_prog_ctrl #(
	parameter int PROG_CYCLES = otp_prog_pkg::BYTE_PROG_CYC
) (
	input  wire logic       REF_CLK,
	input  wire logic       ARST_N,
	input  wire logic       REG_WR,
	input  wire logic       REG_RD,
	input  wire logic [7:0] REG_ADDR,
	input  wire logic [7:0] REG_WDATA,
	input  wire logic       INIT_LOCK,
	output logic      [7:0] REG_RDATA,
	output logic            PROG_BUSY,
	output logic            LOCK_ERR,
	output logic      [7:0] ARRAY_SUM,
	output logic            LPF_SEL
);
	localparam int SW = otp_prog_pkg::SHARED_BYTES * 8;
	localparam int BW = otp_prog_pkg::B2_BYTES * 8;

	// additive byte checksum over a packed block
	function automatic logic [7:0] block_sum(input logic [SW-1:0] blk, input int n);
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < otp_prog_pkg::SHARED_BYTES; i++) begin
			if (i < n) begin
				s = s + blk[i*8 +: 8];
			end
		end
		return s;
	endfunction

	logic [7:0]  ctrl_r, ctrl_nxt;
	logic [SW-1:0] mirror_r, mirror_nxt;
	logic [BW-1:0] b2_r, b2_nxt;
	otp_prog_pkg::bank_t base_r, base_nxt;
	logic [7:0]  rdata_r, rdata_nxt;
	logic [7:0]  arr_sum_r, arr_sum_nxt;
	logic [2:0]  lock_r, lock_nxt;
	logic [7:0]  sum_r [3];
	logic [7:0]  sum_nxt [3];
	otp_prog_pkg::prog_state_t st_r, st_nxt;
	otp_prog_pkg::bank_t tgt_r, tgt_nxt;
	logic [7:0]  burn_sum_r, burn_sum_nxt;
	logic [4:0]  idx_r, idx_nxt;
	logic [15:0] tmr_r, tmr_nxt;
	logic        err_r, err_nxt;
	// nonvolatile cells, no reset: they hold across power cycles
	logic [7:0]  cell_shared [2][otp_prog_pkg::SHARED_BYTES];
	logic [7:0]  cell_b2 [otp_prog_pkg::B2_BYTES];
	logic        cell_we;
	logic [7:0]  cell_wdata;
	logic        wr_ok, req, page_b0, page_b1, page_b2;
	otp_prog_pkg::bank_t req_bank;
	logic [7:0]  live_sum [3];
	logic [4:0]  last_idx;

	// decode of the incoming write and of the requested bank
	always_comb begin
		wr_ok   = REG_WR && !INIT_LOCK;
		page_b0 = REG_ADDR[7:4] == otp_prog_pkg::PAGE_B0;
		page_b1 = REG_ADDR[7:4] == otp_prog_pkg::PAGE_B1;
		page_b2 = REG_ADDR[7:4] == otp_prog_pkg::PAGE_B2
			&& REG_ADDR[3:0] < 4'(otp_prog_pkg::B2_BYTES);
		case (REG_WDATA[otp_prog_pkg::REGION_LSB +: 2])
			otp_prog_pkg::REGION_B0: req_bank = otp_prog_pkg::BANK_0;
			otp_prog_pkg::REGION_B1: req_bank = otp_prog_pkg::BANK_1;
			otp_prog_pkg::REGION_B2: req_bank = (REG_WDATA[otp_prog_pkg::EXA_BIT]
				&& REG_WDATA[otp_prog_pkg::EXB_BIT]) ? otp_prog_pkg::BANK_2
				: otp_prog_pkg::BANK_NONE;
			default: req_bank = otp_prog_pkg::BANK_NONE;
		endcase
		req = wr_ok && REG_ADDR == otp_prog_pkg::ADDR_CTRL
			&& REG_WDATA[otp_prog_pkg::TRIG_BIT];
	end

	// live checksums of the working registers
	always_comb begin
		live_sum[0] = block_sum(mirror_r, otp_prog_pkg::SHARED_BYTES);
		live_sum[1] = live_sum[0];
		live_sum[2] = block_sum(SW'(b2_r), otp_prog_pkg::B2_BYTES);
	end

	// user registers: control, shared mirror, bank two working values
	always_comb begin
		ctrl_nxt    = ctrl_r;
		mirror_nxt  = mirror_r;
		b2_nxt      = b2_r;
		base_nxt    = base_r;
		rdata_nxt   = rdata_r;
		arr_sum_nxt = ctrl_r + live_sum[0] + live_sum[2];
		if (wr_ok) begin
			if (REG_ADDR == otp_prog_pkg::ADDR_CTRL) begin
				ctrl_nxt = REG_WDATA;
			end
			if (page_b0 || page_b1) begin
				mirror_nxt[REG_ADDR[3:0]*8 +: 8] = REG_WDATA;
				base_nxt = page_b0 ? otp_prog_pkg::BANK_0 : otp_prog_pkg::BANK_1;
			end
			if (page_b2) begin
				b2_nxt[REG_ADDR[1:0]*8 +: 8] = REG_WDATA;
			end
		end
		if (REG_RD) begin
			rdata_nxt = 8'h00;
			if (REG_ADDR == otp_prog_pkg::ADDR_CTRL) begin
				rdata_nxt = ctrl_r;
			end else if (page_b0 || page_b1) begin
				rdata_nxt = mirror_r[REG_ADDR[3:0]*8 +: 8];
			end else if (page_b2) begin
				rdata_nxt = b2_r[REG_ADDR[1:0]*8 +: 8];
			end else if (REG_ADDR == otp_prog_pkg::ADDR_SUM_B0) begin
				rdata_nxt = {lock_r[0], sum_r[0][6:0]};
			end else if (REG_ADDR == otp_prog_pkg::ADDR_SUM_B1) begin
				rdata_nxt = {lock_r[1], sum_r[1][6:0]};
			end else if (REG_ADDR == otp_prog_pkg::ADDR_SUM_B2) begin
				rdata_nxt = {lock_r[2], sum_r[2][6:0]};
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ctrl_r    <= otp_prog_pkg::ADDR_CTRL_RST;
			mirror_r  <= '0;
			b2_r      <= '0; // lowpass comes up at 1000 Hz
			base_r    <= otp_prog_pkg::BANK_0;
			rdata_r   <= 8'h00;
			arr_sum_r <= 8'h00;
		end else begin
			ctrl_r    <= ctrl_nxt;
			mirror_r  <= mirror_nxt;
			b2_r      <= b2_nxt;
			base_r    <= base_nxt;
			rdata_r   <= rdata_nxt;
			arr_sum_r <= arr_sum_nxt;
		end
	end

	// programming sequencer: sum, burn byte by byte, then lock
	always_comb begin
		st_nxt       = st_r;
		tgt_nxt      = tgt_r;
		burn_sum_nxt = burn_sum_r;
		idx_nxt      = idx_r;
		tmr_nxt      = tmr_r;
		lock_nxt     = lock_r;
		sum_nxt      = sum_r;
		cell_we      = 1'b0;
		cell_wdata   = 8'h00;
		last_idx     = (tgt_r == otp_prog_pkg::BANK_2) ? 5'(otp_prog_pkg::B2_BYTES - 1)
			: 5'(otp_prog_pkg::SHARED_BYTES - 1);
		case (st_r)
			otp_prog_pkg::ST_IDLE: begin
				// requests are taken only here; a reserved or locked request leaves the sequencer idle
				if (req && req_bank != otp_prog_pkg::BANK_NONE
					&& !lock_r[req_bank]) begin
					tgt_nxt = req_bank;
					st_nxt  = otp_prog_pkg::ST_SUM;
				end
			end
			otp_prog_pkg::ST_SUM: begin
				burn_sum_nxt = live_sum[tgt_r];
				idx_nxt      = 5'h00;
				tmr_nxt      = 16'(PROG_CYCLES - 1);
				st_nxt       = otp_prog_pkg::ST_BURN;
			end
			otp_prog_pkg::ST_BURN: begin
				if (tmr_r == 16'h0000) begin
					cell_we = 1'b1;
					if (tgt_r == otp_prog_pkg::BANK_2) begin
						cell_wdata = b2_r[idx_r[1:0]*8 +: 8];
						if (idx_r == 5'h00) begin
							cell_wdata[otp_prog_pkg::LPF_BIT] = otp_prog_pkg::LPF_1000HZ;
						end
					end else begin
						cell_wdata = mirror_r[idx_r[3:0]*8 +: 8];
					end
					tmr_nxt = 16'(PROG_CYCLES - 1);
					idx_nxt = idx_r + 5'h01;
					if (idx_r == last_idx) begin
						st_nxt = otp_prog_pkg::ST_LOCK;
					end
				end else begin
					tmr_nxt = tmr_r - 16'h0001;
				end
			end
			otp_prog_pkg::ST_LOCK: begin
				// lock the bank; the trigger bit is left as the host wrote it
				lock_nxt[tgt_r] = 1'b1;
				sum_nxt[tgt_r]  = burn_sum_r;
				st_nxt          = otp_prog_pkg::ST_IDLE;
			end
			default: st_nxt = otp_prog_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			st_r       <= otp_prog_pkg::ST_IDLE;
			tgt_r      <= otp_prog_pkg::BANK_0;
			burn_sum_r <= 8'h00;
			idx_r      <= 5'h00;
			tmr_r      <= 16'h0000;
			lock_r     <= 3'h0;
			sum_r      <= '{default: 8'h00};
		end else begin
			st_r       <= st_nxt;
			tgt_r      <= tgt_nxt;
			burn_sum_r <= burn_sum_nxt;
			idx_r      <= idx_nxt;
			tmr_r      <= tmr_nxt;
			lock_r     <= lock_nxt;
			sum_r      <= sum_nxt;
		end
	end

	// nonvolatile cell writes, only from the sequencer
	always_ff @(posedge REF_CLK) begin
		if (cell_we) begin
			if (tgt_r == otp_prog_pkg::BANK_2) begin
				cell_b2[idx_r[1:0]] <= cell_wdata;
			end else begin
				cell_shared[tgt_r[0]][idx_r[3:0]] <= cell_wdata;
			end
		end
	end

	// change detection on locked banks; shared banks checked while in the window
	always_comb begin
		err_nxt = 1'b0;
		if (lock_r[2] && live_sum[2] != sum_r[2]) begin
			err_nxt = 1'b1;
		end
		if (base_r != otp_prog_pkg::BANK_2 && base_r != otp_prog_pkg::BANK_NONE
			&& lock_r[base_r] && live_sum[base_r] != sum_r[base_r]) begin
			err_nxt = 1'b1;
		end
		if (st_r != otp_prog_pkg::ST_IDLE) begin
			err_nxt = 1'b0;
		end
	end

	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			err_r <= 1'b0;
		end else begin
			err_r <= err_nxt;
		end
	end

	// outputs
	assign REG_RDATA = rdata_r;
	assign PROG_BUSY = st_r != otp_prog_pkg::ST_IDLE;
	assign LOCK_ERR  = err_r;
	assign ARRAY_SUM = arr_sum_r;
	assign LPF_SEL   = b2_r[otp_prog_pkg::LPF_BIT];
endmodule

// >>> testbench/otp_prog_ctrl_asserts.sv
// port assertions for the nonvolatile programming controller
`timescale 1ns/100ps
module otp_prog_ctrl_asserts #(parameter int PROG_CYCLES = 4) (
	input wire logic       REF_CLK,
	input wire logic       ARST_N,
	input wire logic       REG_WR,
	input wire logic       REG_RD,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic       INIT_LOCK,
	input wire logic [7:0] REG_RDATA,
	input wire logic       PROG_BUSY,
	input wire logic       LOCK_ERR,
	input wire logic [7:0] ARRAY_SUM,
	input wire logic       LPF_SEL
);
	default clocking dc @(posedge REF_CLK); endclocking
	default disable iff (!ARST_N);
	// accepted control register write
	wire cw = REG_WR && !INIT_LOCK && REG_ADDR == 8'h11;
	// idle trigger carrying a reserved selection
	sequence bad_s;
		cw && !PROG_BUSY && REG_WDATA[7] && (REG_WDATA[1:0] == 2'h3 ||
			REG_WDATA[3:0] inside {4'h2, 4'h6, 4'hA});
	endsequence
	a_start_cause: assert property ($rose(PROG_BUSY) |-> $past(cw && REG_WDATA[7]))
		else $error("programming began with no trigger");
	a_refused_idle: assert property (bad_s |=> !PROG_BUSY [*4])
		else $error("reserved selection started programming");
	// the change flag is registered, so it is cleared one cycle into programming, at the first burn cycle
	a_no_err_busy: assert property (PROG_BUSY && $past(PROG_BUSY) |-> !LOCK_ERR)
		else $error("change flag raised during programming");
	a_rdata_holds: assert property (!REG_RD |=> $stable(REG_RDATA))
		else $error("read data moved without a read");
	a_lock_freeze: assert property (INIT_LOCK [*4] |-> $stable(ARRAY_SUM))
		else $error("registers changed under init lock");
	a_lpf_by_write: assert property ($changed(LPF_SEL) |->
		$past(REG_WR && !INIT_LOCK && REG_ADDR == 8'hC0)) else $error("lowpass moved alone");
	a_burn_min_len: assert property ($rose(PROG_BUSY) |-> PROG_BUSY [*8])
		else $error("programming ended too early");
	a_burn_ends: assert property ($rose(PROG_BUSY) |-> ##[1:1000] !PROG_BUSY)
		else $error("programming did not finish");
endmodule
bind otp_prog_ctrl otp_prog_ctrl_asserts #(.PROG_CYCLES(PROG_CYCLES)) chk (.REF_CLK(REF_CLK),
	.ARST_N(ARST_N), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .LPF_SEL(LPF_SEL),
	.REG_WDATA(REG_WDATA), .INIT_LOCK(INIT_LOCK), .REG_RDATA(REG_RDATA), .PROG_BUSY(PROG_BUSY),
	.LOCK_ERR(LOCK_ERR), .ARRAY_SUM(ARRAY_SUM));

// >>> testbench/otp_prog_ctrl_bench.sv
// self-checking bench for the nonvolatile programming controller
`timescale 1ns/100ps
module otp_prog_ctrl_bench;
	logic       clk = 1'b0, rst_n = 1'b0, ilock = 1'b0, wr, rd, busy, lerr, lowpass_filter_setting;
	logic [7:0] addr, wd, rdat, sum, rv;
	int         error_cnt = 0, comparisons = 0;
	// clock, design and host model
	always #50 clk = ~clk;
	otp_prog_ctrl #(.PROG_CYCLES(4)) dut (.REF_CLK(clk), .ARST_N(rst_n), .REG_WR(wr), .REG_RD(rd),
		.REG_ADDR(addr), .REG_WDATA(wd), .INIT_LOCK(ilock), .REG_RDATA(rdat), .PROG_BUSY(busy),
		.LOCK_ERR(lerr), .ARRAY_SUM(sum), .LPF_SEL(lowpass_filter_setting));
	reg_host_model host (.clk(clk), .rdata(rdat), .wr(wr), .rd(rd), .addr(addr), .wdata(wd));
	// count and judge one comparison
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// masked register read
	task automatic rdm(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
		host.acc(1'b0, a, 8'h00, rv);
		chk(rv & m, exp);
	endtask
	// register write, then the busy flag
	task automatic wrb(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
		host.acc(1'b1, a, d, rv);
		chk(8'(busy), exp);
	endtask
	// bounded wait for programming to end
	task automatic wait_idle;
		for (int n = 0; n < 3000 && busy !== 1'b0; n++) #100;
		chk(8'(busy), 8'h00);
	endtask
	// reset value, bank zero, a second request during the burn
	task automatic t_bank_zero;
		rdm(8'h11, 8'hFF, 8'h00);
		for (int i = 0; i < 16; i++)
			wrb(8'hA0 + 8'(i), 8'(i), 8'h00);
		wrb(8'h11, 8'h80, 8'h01);
		wrb(8'h11, 8'h81, 8'h01);
		wait_idle;
		rdm(8'hE0, 8'h80, 8'h80);
		chk(dut.cell_shared[0][15], 8'h0F);
		rdm(8'hE1, 8'h80, 8'h00);
		rdm(8'h11, 8'hFF, 8'h81);
		chk(sum, 8'hF9);
	endtask
	// locked bank, reserved selections, then writes under init lock
	task automatic t_refused;
		logic [7:0] c [5] = '{8'h80, 8'h83, 8'h82, 8'h86, 8'h8A};
		foreach (c[i])
			wrb(8'h11, c[i], 8'h00);
		ilock = 1'b1;
		wrb(8'h11, 8'h03, 8'h00);
		wrb(8'hC0, 8'h01, 8'h00);
		chk(8'(lowpass_filter_setting), 8'h00);
		rdm(8'h11, 8'hFF, 8'h8A);
		ilock = 1'b0;
	endtask
	// bank one through the moved shared base
	task automatic t_bank_one;
		rdm(8'hE1, 8'h80, 8'h00);
		wrb(8'hB0, 8'h10, 8'h00);
		wrb(8'h11, 8'h81, 8'h01);
		wait_idle;
		rdm(8'hE1, 8'h80, 8'h80);
		rdm(8'hB1, 8'hFF, 8'h01);
		chk(dut.cell_shared[1][0], 8'h10);
		chk(dut.cell_shared[1][1], 8'h01);
		wrb(8'hB2, 8'hFF, 8'h00);
		rdm(8'hB2, 8'hFF, 8'hFF);
		chk(8'(lerr), 8'h01);
		chk(dut.cell_shared[1][2], 8'h02);
		wrb(8'hB2, 8'h02, 8'h00);
		rdm(8'hB2, 8'hFF, 8'h02);
		chk(8'(lerr), 8'h00);
		chk(dut.cell_shared[0][0], 8'h00);
	endtask
	// bank two, change detection, lowpass setting, refused reprogram
	task automatic t_bank_two;
		wrb(8'hC0, 8'h01, 8'h00);
		wrb(8'h11, 8'h8E, 8'h01);
		wait_idle;
		rdm(8'hE2, 8'h80, 8'h80);
		chk(dut.cell_b2[0], 8'h00);
		wrb(8'hC1, 8'h5A, 8'h00);
		rdm(8'hC1, 8'hFF, 8'h5A);
		chk(8'(lerr), 8'h01);
		wrb(8'hC0, 8'h00, 8'h00);
		chk(8'(lowpass_filter_setting), 8'h00);
		wrb(8'h11, 8'h8E, 8'h00);
	endtask
	// mid-run reset: lowpass back at 1000 Hz, control register cleared
	task automatic t_reset;
		wrb(8'hC0, 8'h01, 8'h00);
		chk(8'(lowpass_filter_setting), 8'h01);
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		#1 rst_n = 1'b1;
		chk(8'(lowpass_filter_setting), 8'h00);
		rdm(8'h11, 8'hFF, 8'h00);
	endtask
	// reset, scenarios, verdict
	initial begin
		repeat (8) @(posedge clk);
		#1 rst_n = 1'b1;
		t_bank_zero;
		t_refused;
		t_bank_one;
		t_bank_two;
		t_reset;
		end_of_test;
	end
	// watchdog far beyond the expected run
	initial begin
		#2000000 error_cnt++;
		end_of_test;
	end
	// counts, verdict, stop
	task automatic end_of_test;
		$display("mismatches %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
endmodule

// >>> testbench/reg_host_model.sv
// host model: byte accesses on the internal register port
`timescale 1ns/100ps
module reg_host_model (
	input  wire logic       clk,
	input  wire logic [7:0] rdata,
	output logic            wr,
	output logic            rd,
	output logic      [7:0] addr,
	output logic      [7:0] wdata
);
	// idle lines at time zero, parked away from any real request
	initial {wr, rd, addr, wdata} = 18'h0FFFF;
	// one strobe for one edge; a read answer is taken the cycle after
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk);
		#1;
		{wr, rd, addr, wdata} = {w, !w, a, d};
		@(posedge clk);
		#1;
		{wr, rd, addr, wdata} = {2'b00, ~a, ~d};
		q = rdata;
	endtask
endmodule
